// ---- design/vector_select_defs.svh ----
// Constants for the reset and interrupt vector selector
`ifndef VECTOR_SELECT_DEFS_SVH
`define VECTOR_SELECT_DEFS_SVH

`define IVS_ADDR_W          12
`define IVS_NUM_SRC         25
`define IVS_RESET_ADDR      12'h000
`define IVS_FUSE_PROGRAMMED 1'h0
`define IVS_OFF_EXT0        12'h001
`define IVS_OFF_EXT1        12'h002
`define IVS_OFF_PCG0        12'h003
`define IVS_OFF_PCG1        12'h004
`define IVS_OFF_PCG2        12'h005
`define IVS_OFF_WDOG        12'h006
`define IVS_OFF_T2_MA       12'h007
`define IVS_OFF_T2_MB       12'h008
`define IVS_OFF_T2_OVF      12'h009
`define IVS_OFF_T1_CAP      12'h00A
`define IVS_OFF_T1_MA       12'h00B
`define IVS_OFF_T1_MB       12'h00C
`define IVS_OFF_T1_OVF      12'h00D
`define IVS_OFF_T0_MA       12'h00E
`define IVS_OFF_T0_MB       12'h00F
`define IVS_OFF_T0_OVF      12'h010
`define IVS_OFF_SPX         12'h011
`define IVS_OFF_RXC         12'h012
`define IVS_OFF_TXE         12'h013
`define IVS_OFF_TXC         12'h014
`define IVS_OFF_CONV        12'h015
`define IVS_OFF_NVM         12'h016
`define IVS_OFF_ACMP        12'h017
`define IVS_OFF_TWO_WIRE    12'h018
`define IVS_OFF_STORE       12'h019

`endif

// ---- design/vector_select_pkg.sv ----
// Types shared by the vector selector and its bench
package vector_select_pkg;
  `include "vector_select_defs.svh"

  // Sequencer states
  typedef enum logic [1:0] {
    ST_START = 2'b00,
    ST_RESET = 2'b01,
    ST_IDLE  = 2'b10,
    ST_IRQ   = 2'b11
  } vec_state_e;

  // Vector offered to the core
  typedef struct packed {
    logic                   valid;
    logic                   is_reset;
    logic [4:0]             num;
    logic [`IVS_ADDR_W-1:0] addr;
  } vec_out_s;

  // Whole state of the selector
  typedef struct packed {
    vec_state_e state;
    vec_out_s   out;
  } ctl_s;
endpackage

// ---- design/reset_interrupt_vector_select.sv ----
// Reset and interrupt vector address generator for the core fetch unit
//
// Behaviour
// - Unprogrammed fuse: every reset starts at 0x000.
// - Programmed fuse: reset starts at boot address.
// - Vector select set: vectors offset by boot start.
// - Fuse 1 unprogrammed, 0 programmed.
// - Select set: table starts boot address plus 0x001.
// - Select clear: table starts at 0x001.
// - External 0, 1, watchdog at 0x001, 0x002, 0x006.
// - Pin-change groups 0-2 at 0x003 to 0x005.
// - Timer 2 matches, overflow at 0x007-0x009.
// - Timer 1 capture, matches at 0x00A-0x00C.
// - Timer 1 overflow, timer 0 matches 0x00D-0x00F.
// - Timer 0 overflow 0x010, serial periph 0x011.
// - Serial port events at 0x012 to 0x014.
// - Converter, data memory, comparator 0x015-0x017.
// - Two-wire 0x018, program store 0x019, last.
`timescale 1ns/1ps
`default_nettype none
`include "vector_select_defs.svh"

module reset_interrupt_vector_select (
  // Clock and reset
  input  wire logic                        clk,
  input  wire logic                        rst,
  // Configuration
  input  wire logic                        boot_reset_fuse,
  input  wire logic                        vector_select_bit,
  input  wire logic [`IVS_ADDR_W-1:0]      boot_reset_addr,
  // Requests, already masked by the flag logic
  input  wire logic [`IVS_NUM_SRC-1:0]     irq_req,
  // Core handshake
  input  wire logic                        core_accept,
  input  wire logic                        vec_ack,
  output var  vector_select_pkg::vec_out_s vec_out
);

  // Registered state and its next value
  vector_select_pkg::ctl_s cur_reg;
  vector_select_pkg::ctl_s cur_next;

  // Lowest set request bit; bit 0 has top priority
  function automatic logic [4:0] lowest_index(input logic [`IVS_NUM_SRC-1:0] r);
    logic [4:0] idx;
    idx = 5'h00;
    for (int i = `IVS_NUM_SRC - 1; i >= 0; i--) begin
      if (r[i]) begin
        idx = 5'(i);
      end
    end
    return idx;
  endfunction

  // Table offset of each source bit
  function automatic logic [`IVS_ADDR_W-1:0] vector_offset(input logic [4:0] idx);
    logic [`IVS_ADDR_W-1:0] off;
    off = `IVS_OFF_EXT0;
    case (idx)
      5'h00: off = `IVS_OFF_EXT0;
      5'h01: off = `IVS_OFF_EXT1;
      5'h02: off = `IVS_OFF_PCG0;
      5'h03: off = `IVS_OFF_PCG1;
      5'h04: off = `IVS_OFF_PCG2;
      5'h05: off = `IVS_OFF_WDOG;
      5'h06: off = `IVS_OFF_T2_MA;
      5'h07: off = `IVS_OFF_T2_MB;
      5'h08: off = `IVS_OFF_T2_OVF;
      5'h09: off = `IVS_OFF_T1_CAP;
      5'h0A: off = `IVS_OFF_T1_MA;
      5'h0B: off = `IVS_OFF_T1_MB;
      5'h0C: off = `IVS_OFF_T1_OVF;
      5'h0D: off = `IVS_OFF_T0_MA;
      5'h0E: off = `IVS_OFF_T0_MB;
      5'h0F: off = `IVS_OFF_T0_OVF;
      5'h10: off = `IVS_OFF_SPX;
      5'h11: off = `IVS_OFF_RXC;
      5'h12: off = `IVS_OFF_TXE;
      5'h13: off = `IVS_OFF_TXC;
      5'h14: off = `IVS_OFF_CONV;
      5'h15: off = `IVS_OFF_NVM;
      5'h16: off = `IVS_OFF_ACMP;
      5'h17: off = `IVS_OFF_TWO_WIRE;
      5'h18: off = `IVS_OFF_STORE;
      default: off = `IVS_OFF_EXT0;   // Out of range bits never set
    endcase
    return off;
  endfunction

  // Table base: boot start when relocated, else zero
  function automatic logic [`IVS_ADDR_W-1:0] table_base(input logic sel,
                                                        input logic [`IVS_ADDR_W-1:0] boot);
    return sel ? boot : `IVS_RESET_ADDR;
  endfunction

  // Winning source, decoded once for the next-state logic
  logic [4:0] win_idx;
  assign win_idx = lowest_index(irq_req);

  // Next-state logic
  always_comb begin
    cur_next = cur_reg;
    case (cur_reg.state)
      vector_select_pkg::ST_START: begin
        // Fuse is read only after reset release, so a strap change is seen cleanly
        cur_next.state        = vector_select_pkg::ST_RESET;
        cur_next.out.valid    = 1'b1;
        cur_next.out.is_reset = 1'b1;
        cur_next.out.num      = 5'h01;
        if (boot_reset_fuse == `IVS_FUSE_PROGRAMMED) begin
          cur_next.out.addr = boot_reset_addr;
        end else begin
          cur_next.out.addr = `IVS_RESET_ADDR;
        end
      end
      vector_select_pkg::ST_RESET, vector_select_pkg::ST_IRQ: begin
        // Vector held stable until the core takes it
        if (vec_ack) begin
          cur_next.state        = vector_select_pkg::ST_IDLE;
          cur_next.out.valid    = 1'b0;
          cur_next.out.is_reset = 1'b0;
        end
      end
      vector_select_pkg::ST_IDLE: begin
        // Core gates dispatch; without its accept the table is never fetched
        if (core_accept && (|irq_req)) begin
          cur_next.state        = vector_select_pkg::ST_IRQ;
          cur_next.out.valid    = 1'b1;
          cur_next.out.is_reset = 1'b0;
          cur_next.out.num      = 5'(win_idx + 5'h02);
          cur_next.out.addr     = 12'(table_base(vector_select_bit, boot_reset_addr)
                                      + vector_offset(win_idx));
        end
      end
      default: begin
        cur_next.state = vector_select_pkg::ST_START;
      end
    endcase
  end

  // State register
  always_ff @(posedge clk) begin
    if (rst) begin
      cur_reg.state        <= vector_select_pkg::ST_START;
      cur_reg.out.valid    <= 1'b0;
      cur_reg.out.is_reset <= 1'b0;
      cur_reg.out.num      <= 5'h00;
      cur_reg.out.addr     <= `IVS_RESET_ADDR;
    end else begin
      cur_reg <= cur_next;
    end
  end

  // Outputs come straight from the state register
  assign vec_out = cur_reg.out;

  // Grant condition used by the checks
  logic grant;
  assign grant = (cur_reg.state == vector_select_pkg::ST_IDLE) && core_accept && (|irq_req);

  // Checks run only out of reset; the offer is judged one edge after its cause
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  AST_RESET_ZERO: assert property (
    (cur_reg.state == vector_select_pkg::ST_START) && boot_reset_fuse
    |=> vec_out.valid && vec_out.is_reset && (vec_out.addr == `IVS_RESET_ADDR))
    else $error("reset vector not zero with fuse unprogrammed");

  AST_RESET_BOOT: assert property (
    (cur_reg.state == vector_select_pkg::ST_START) && !boot_reset_fuse
    |=> vec_out.is_reset && (vec_out.addr == $past(boot_reset_addr)))
    else $error("reset vector not boot address with fuse programmed");

  AST_FUSE_DECODE: assert property (
    (cur_reg.state == vector_select_pkg::ST_START)
    |=> (vec_out.addr == ($past(boot_reset_fuse) ? `IVS_RESET_ADDR : $past(boot_reset_addr))))
    else $error("fuse polarity decoded wrongly");

  AST_TABLE_LOW: assert property (
    grant && !vector_select_bit
    |=> vec_out.valid && (vec_out.addr == 12'(lowest_index($past(irq_req))) + `IVS_OFF_EXT0))
    else $error("vector address wrong with select clear");

  AST_TABLE_BOOT: assert property (
    grant && vector_select_bit
    |=> (vec_out.addr == 12'($past(boot_reset_addr) + `IVS_OFF_EXT0
                             + 12'(lowest_index($past(irq_req))))))
    else $error("vector address wrong with select set");

  AST_EXT0_WINS: assert property (
    grant && irq_req[0] |=> (vec_out.num == 5'h02) && !vec_out.is_reset)
    else $error("external request 0 did not win");

  AST_WDOG_ONLY: assert property (
    grant && !vector_select_bit && (irq_req == 25'h0000020)
    |=> (vec_out.addr == `IVS_OFF_WDOG))
    else $error("watchdog vector wrong");

  AST_LAST_VEC: assert property (
    grant && !vector_select_bit && (irq_req == 25'h1000000)
    |=> (vec_out.addr == `IVS_OFF_STORE) && (vec_out.num == 5'h1A))
    else $error("last vector wrong");

  AST_HOLD: assert property (
    vec_out.valid && !vec_ack |=> vec_out.valid && $stable(vec_out.addr))
    else $error("vector changed before acknowledge");

  // Dispatch waits for the core; a pending request alone must not raise an offer
  AST_NO_ACCEPT: assert property (
    (cur_reg.state == vector_select_pkg::ST_IDLE) && !core_accept
    |=> !vec_out.valid)
    else $error("vector offered without core accept");

  AST_RELEASE: assert property (
    vec_out.valid && vec_ack |=> !vec_out.valid ##1 (vec_out.valid == $past(grant)))
    else $error("vector not released after acknowledge");

  COV_BOOT_RESET: cover property (
    (cur_reg.state == vector_select_pkg::ST_START) && !boot_reset_fuse ##1 vec_out.valid);
  COV_RELOCATED_IRQ: cover property (grant && vector_select_bit ##1 vec_out.valid);
  COV_COLLISION: cover property (grant && irq_req[0] && irq_req[24]);
  COV_BACK_TO_BACK: cover property (vec_out.valid && vec_ack ##1 grant);

endmodule
`default_nettype wire

// ---- test/vec_core_model.sv ----
// Core fetch model that takes the vectors the selector offers
`timescale 1ns/1ps
`default_nettype none

module vec_core_model (
  // Clock and reset
  input  wire logic                        clk,
  input  wire logic                        rst,
  // Cycles to sit on an offer before taking it
  input  wire logic [3:0]                  lag,
  // Selector side
  input  wire vector_select_pkg::vec_out_s vec_out,
  output var  logic                        vec_ack,
  // Last vector taken and how many so far
  output var  vector_select_pkg::vec_out_s taken,
  output var  int                          n_taken
);
  logic [3:0] wait_cnt;  // Cycles the current offer has stood

  // Ack rises after a falling edge and is held over the sampling edge
  always @(negedge clk) begin
    if (rst) begin
      vec_ack  <= 1'b0;  // Quiet start so the first offer is not acked by chance
      wait_cnt <= 4'h0;
      n_taken  <= 0;
    end else if (!vec_out.valid || vec_ack) begin
      vec_ack  <= 1'b0;  // One ack per offer, never two edges in a row
      wait_cnt <= 4'h0;
    end else if (wait_cnt >= lag) begin
      vec_ack  <= 1'b1;
      taken    <= vec_out;
      n_taken  <= n_taken + 1;
      wait_cnt <= 4'h0;
    end else begin
      vec_ack  <= 1'b0;
      wait_cnt <= wait_cnt + 4'h1;  // Slow core lets the offer stand
    end
  end
endmodule

`default_nettype wire

// ---- test/tb_reset_interrupt_vector_select.sv ----
// Testbench for the reset and interrupt vector selector
`timescale 1ns/1ps
`default_nettype none

module tb_reset_interrupt_vector_select;
  logic                        clk = 1'b0;
  logic                        rst;
  logic                        boot_reset_fuse;
  logic                        vector_select_bit = 1'b0;
  logic [11:0]                 boot_reset_addr = 12'hC00;
  logic [24:0]                 irq_req;
  logic                        core_accept = 1'b1;
  logic [3:0]                  lag = 4'h0;
  logic                        vec_ack;
  vector_select_pkg::vec_out_s vec_out;
  vector_select_pkg::vec_out_s taken;
  int                          n_taken;
  int                          n_errors = 0;
  int                          cmp_count = 0;

  always #12.5 clk = ~clk;

  reset_interrupt_vector_select i_reset_interrupt_vector_select (
    .clk(clk), .rst(rst), .boot_reset_fuse(boot_reset_fuse),
    .vector_select_bit(vector_select_bit), .boot_reset_addr(boot_reset_addr),
    .irq_req(irq_req), .core_accept(core_accept), .vec_ack(vec_ack), .vec_out(vec_out));

  vec_core_model i_vec_core_model (
    .clk(clk), .rst(rst), .lag(lag), .vec_out(vec_out), .vec_ack(vec_ack),
    .taken(taken), .n_taken(n_taken));

  // Compare and count
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask

  // Bounded wait for the core to take one more vector
  task automatic wait_take();
    int n0;
    logic ok;
    n0 = n_taken;
    ok = 1'b0;
    repeat (40) begin
      @(negedge clk);
      #1;
      if (n_taken != n0) begin
        ok = 1'b1;
        break;
      end
    end
    check("vector taken", ok, 1);
  endtask

  // A pending request must not jump ahead of the reset vector
  task automatic reset_case(input logic fuse, input logic [11:0] exp_addr);
    rst = 1'b1;
    boot_reset_fuse = fuse;
    irq_req = 25'h1;
    repeat (2) @(negedge clk);
    rst = 1'b0;
    wait_take();
    irq_req = 25'h0;
    check("reset flag", taken.is_reset, 1);
    check("reset num", taken.num, 5'h01);
    check("reset addr", taken.addr, exp_addr);
    @(negedge clk);  // Next task drives on a fresh falling edge
  endtask

  // Requests are dropped once taken so each grant is a fresh one
  task automatic irq_case(input logic [24:0] req, input logic sel, input logic [11:0] base,
                          input logic [4:0] exp_num, input logic [11:0] exp_off);
    logic [11:0] exp_addr;
    exp_addr = (sel ? base : 12'h000) + exp_off;  // Wraps in 12 bits on purpose
    irq_req = req;
    vector_select_bit = sel;
    boot_reset_addr = base;
    wait_take();
    irq_req = 25'h0;
    check("irq num", taken.num, exp_num);
    check("irq addr", taken.addr, exp_addr);
    @(negedge clk);  // Next task drives on a fresh falling edge
  endtask

  // Every source alone, slot i at offset i plus one
  task automatic sweep(input logic sel, input logic [11:0] base);
    for (int i = 0; i < 25; i++) begin
      irq_case(25'h1 << i, sel, base, 5'(i + 2), 12'(i + 1));
    end
  endtask

  // No grant while the core is not ready
  task automatic hold_case();
    int n0;
    core_accept = 1'b0;
    irq_req = 25'h20;
    n0 = n_taken;
    repeat (6) @(negedge clk);
    check("held takes", n_taken - n0, 0);
    check("held valid", vec_out.valid, 0);
    core_accept = 1'b1;
    irq_case(25'h20, 1'b0, 12'hC00, 5'h07, 12'h006);
  endtask

  // Verdict
  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // Main sequence
  initial begin
    reset_case(1'b1, 12'h000);
    sweep(1'b0, 12'hC00);
    reset_case(1'b0, 12'hC00);
    lag = 4'h3;  // Slow core from here on
    sweep(1'b1, 12'hC00);
    irq_case(25'h1000000, 1'b1, 12'hFF0, 5'h1A, 12'h019);
    irq_case(25'h1000408, 1'b0, 12'hC00, 5'h05, 12'h004);
    irq_case(25'h1000400, 1'b0, 12'hC00, 5'h0C, 12'h00B);
    irq_case(25'h1000001, 1'b0, 12'hC00, 5'h02, 12'h001);
    hold_case();
    tally_and_finish();
  end

  // Hang guard, well past the few hundred cycles the tests need
  initial begin
    #(4000 * 25);
    n_errors++;
    tally_and_finish();
  end
endmodule

`default_nettype wire
